// ==== rtl/fsucr_pkg.sv ====
`default_nettype none
package fsucr_pkg;
    localparam int NUM_SETS = 4;
    localparam int ADDR_W   = 4;
    localparam int DATA_W   = 8;
    localparam int PTR_W    = 8;

    // register offsets on the plain port
    localparam logic [3:0] OFS_ID_FUNC_CTRL  = 4'h0;
    localparam logic [3:0] OFS_SET_ENABLE    = 4'h1;
    localparam logic [3:0] OFS_SET_IRQ_EN    = 4'h2;
    localparam logic [3:0] OFS_INDEX_SELECT  = 4'h3;
    localparam logic [3:0] OFS_XFER_FLAGS    = 4'h4;
    localparam logic [3:0] OFS_WINDOW_PORT   = 4'h5;

    // field positions
    localparam int ID_FUNC_RSVD_LSB = 6;
    localparam int IDX_SET_LSB      = 5;
    localparam int IDX_KIND_BIT     = 4;
    localparam int IDX_PTR_LSB      = 2;
    localparam int IDX_STS_LSB      = 0;

    // reset values
    localparam logic [7:0] RST_ID_FUNC   = 8'h00;
    localparam logic [7:0] RST_SET_EN    = 8'h00;
    localparam logic [7:0] RST_IRQ_EN    = 8'h00;
    localparam logic [7:0] RST_INDEX_SEL = 8'h00;
    localparam logic [3:0] RST_FLAGS     = 4'h0;
    localparam logic [7:0] RST_PTR       = 8'h00;

    // pointer field codes (kind select = 0)
    localparam logic [1:0] PTR_BASE  = 2'h0;
    localparam logic [1:0] PTR_READ  = 2'h1;
    localparam logic [1:0] PTR_WRITE = 2'h2;
    localparam logic [1:0] PTR_TEMP  = 2'h3;

    // status field codes (kind select = 1)
    localparam logic [1:0] STS_VALID_COUNT = 2'h0;
    localparam logic [1:0] STS_FREE_COUNT  = 2'h1;
    localparam logic [1:0] STS_NEXT_READ   = 2'h2;
    localparam logic [1:0] STS_NEXT_WRITE  = 2'h3;
endpackage : fsucr_pkg
`default_nettype wire

// ==== rtl/fsucr_regs.sv ====
// Design decisions made here: the plain strobed port and the placing of the registers.
`default_nettype none
module fsucr_regs
    import fsucr_pkg::*;
(
    input  wire logic                           clk,
    input  wire logic                           sys_rst,
    input  wire logic [fsucr_pkg::ADDR_W-1:0]   reg_addr,
    input  wire logic [fsucr_pkg::DATA_W-1:0]   reg_wdata,
    input  wire logic                           reg_wr,
    input  wire logic                           reg_rd,
    output var  logic [fsucr_pkg::DATA_W-1:0]   reg_rdata,
    input  wire logic [fsucr_pkg::NUM_SETS-1:0] buffer_overflow_read,
    input  wire logic [fsucr_pkg::NUM_SETS-1:0] buffer_overflow_write,
    input  wire logic [fsucr_pkg::NUM_SETS-1:0] fifo_full,
    input  wire logic [fsucr_pkg::NUM_SETS-1:0] fifo_empty,
    input  wire logic [4*fsucr_pkg::PTR_W-1:0]  valid_byte_count,
    input  wire logic [4*fsucr_pkg::PTR_W-1:0]  free_byte_count,
    input  wire logic [4*fsucr_pkg::PTR_W-1:0]  next_read_start,
    input  wire logic [4*fsucr_pkg::PTR_W-1:0]  next_write_start,
    output var  logic [fsucr_pkg::NUM_SETS-1:0] pointer_set_enable,
    output var  logic [fsucr_pkg::NUM_SETS-1:0] empty_restore,
    output var  logic [2:0]                     set_index_select,
    output var  logic [4*fsucr_pkg::PTR_W-1:0]  base_pointer,
    output var  logic [4*fsucr_pkg::PTR_W-1:0]  read_pointer,
    output var  logic [4*fsucr_pkg::PTR_W-1:0]  write_pointer,
    output var  logic [4*fsucr_pkg::PTR_W-1:0]  temporary_pointer,
    output var  logic                           transfer_irq
);
    import fsucr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // storage
    logic [1:0]          id_func_rsvd_reg;
    logic [7:0]          set_enable_reg;
    logic [7:0]          irq_enable_reg;
    logic [7:0]          index_select_reg;
    typedef enum logic [1:0] {
        KIND_DIRECT = 2'b01,
        KIND_ARMED  = 2'b10
    } fsucr_arm_t;
    fsucr_arm_t          arm_reg;
    logic [3:0]          flags_reg;
    logic [3:0]          flags_next;
    logic [3:0]          events_prev_reg;
    logic [3:0]          events_now;
    logic [PTR_W-1:0]    ptr_reg [16];
    logic [DATA_W-1:0]   rdata_next;
    logic [DATA_W-1:0]   window_rd;
    logic                wr_id;
    logic                wr_en;
    logic                wr_ie;
    logic                wr_idx;
    logic                wr_flags;
    logic                wr_window;
    logic [2:0]          sel_set;
    logic                sel_kind;
    logic [1:0]          sel_ptr;
    logic [1:0]          sel_sts;
    logic                set_in_range;

    // picks one set's byte out of a packed per-set vector
    function automatic logic [PTR_W-1:0] pick_set(
        input logic [4*PTR_W-1:0] vec,
        input logic [1:0]         set
    );
        pick_set = vec[set*PTR_W +: PTR_W];
    endfunction

    // one strobe hitting one register offset
    function automatic logic reg_hit(
        input logic              strobe,
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] ofs
    );
        reg_hit = strobe && (addr == ofs);
    endfunction

    // flat storage slot of one pointer of one set
    function automatic logic [3:0] ptr_slot(
        input logic [1:0] set,
        input logic [1:0] field
    );
        ptr_slot = {set, field};
    endfunction

    assign wr_id     = reg_hit(reg_wr, reg_addr, OFS_ID_FUNC_CTRL);
    assign wr_en     = reg_hit(reg_wr, reg_addr, OFS_SET_ENABLE);
    assign wr_ie     = reg_hit(reg_wr, reg_addr, OFS_SET_IRQ_EN);
    assign wr_idx    = reg_hit(reg_wr, reg_addr, OFS_INDEX_SELECT);
    assign wr_flags  = reg_hit(reg_wr, reg_addr, OFS_XFER_FLAGS);
    assign wr_window = reg_hit(reg_wr, reg_addr, OFS_WINDOW_PORT);

    assign sel_set      = index_select_reg[IDX_SET_LSB +: 3];
    assign sel_kind     = index_select_reg[IDX_KIND_BIT];
    assign sel_ptr      = index_select_reg[IDX_PTR_LSB +: 2];
    assign sel_sts      = index_select_reg[IDX_STS_LSB +: 2];
    // only sets 0..3 exist; index 4..7 reaches nothing
    assign set_in_range = (sel_set[2] == 1'b0);

    ////////////////////////////////////////////////////////////////////////
    // control registers
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            id_func_rsvd_reg <= RST_ID_FUNC[ID_FUNC_RSVD_LSB +: 2];
        else if (wr_id)
            id_func_rsvd_reg <= reg_wdata[ID_FUNC_RSVD_LSB +: 2];
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            set_enable_reg <= RST_SET_EN;
        else if (wr_en)
            set_enable_reg <= reg_wdata;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            irq_enable_reg <= RST_IRQ_EN;
        else if (wr_ie)
            irq_enable_reg <= reg_wdata;
    end

    // leaving kind 0 for kind 1 takes two writes in a row with the bit set,
    // so a stray single write cannot switch the window to status values
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            index_select_reg <= RST_INDEX_SEL;
            arm_reg          <= KIND_DIRECT;
        end
        else if (wr_idx)
        begin
            unique case (arm_reg)
                KIND_DIRECT:
                begin
                    if (reg_wdata[IDX_KIND_BIT] && !sel_kind)
                    begin
                        index_select_reg <= {reg_wdata[7:5], 1'b0,
                                             reg_wdata[3:0]};
                        arm_reg          <= KIND_ARMED;
                    end
                    else
                        index_select_reg <= reg_wdata;
                end
                KIND_ARMED:
                begin
                    index_select_reg <= reg_wdata;
                    arm_reg          <= KIND_DIRECT;
                end
                // a corrupted state code falls back to plain writes
                default:
                begin
                    index_select_reg <= reg_wdata;
                    arm_reg          <= KIND_DIRECT;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // restore of empty information on re-enable
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            empty_restore <= 4'h0;
        else if (wr_en)
            empty_restore <= reg_wdata[3:0] & ~set_enable_reg[3:0];
        else
            empty_restore <= 4'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // transfer flags and interrupt
    assign events_now = buffer_overflow_read | buffer_overflow_write |
                        fifo_full | fifo_empty;

    // conditions standing at release count as old, so a fifo that is
    // simply empty after reset raises no flag of its own
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            events_prev_reg <= events_now;
        else
            events_prev_reg <= events_now;
    end

    // a rising condition wins over a same-cycle software clear
    always_comb
    begin
        flags_next = flags_reg;
        if (wr_flags)
            flags_next = flags_reg & reg_wdata[3:0];
        flags_next = flags_next | (events_now & ~events_prev_reg);
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            flags_reg <= RST_FLAGS;
        else
            flags_reg <= flags_next;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            transfer_irq <= 1'b0;
        else
            transfer_irq <= |(flags_reg & irq_enable_reg[3:0]);
    end

    ////////////////////////////////////////////////////////////////////////
    // per-set pointers, index = set * 4 + pointer field
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < 16; i++)
                ptr_reg[i] <= RST_PTR;
        end
        else if (wr_window && set_in_range && !sel_kind)
            ptr_reg[ptr_slot(sel_set[1:0], sel_ptr)] <= reg_wdata;
    end

    always_comb
    begin
        window_rd = 8'h00;
        if (set_in_range)
        begin
            if (!sel_kind)
                window_rd = ptr_reg[ptr_slot(sel_set[1:0], sel_ptr)];
            else
            begin
                unique case (sel_sts)
                    STS_VALID_COUNT: window_rd =
                        pick_set(valid_byte_count, sel_set[1:0]);
                    STS_FREE_COUNT:  window_rd =
                        pick_set(free_byte_count, sel_set[1:0]);
                    STS_NEXT_READ:   window_rd =
                        pick_set(next_read_start, sel_set[1:0]);
                    STS_NEXT_WRITE:  window_rd =
                        pick_set(next_write_start, sel_set[1:0]);
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path, data one cycle after the strobe, zero otherwise
    always_comb
    begin
        rdata_next = 8'h00;
        if (reg_rd)
        begin
            unique case (reg_addr)
                OFS_ID_FUNC_CTRL: rdata_next = {id_func_rsvd_reg,
                                                6'h00};
                OFS_SET_ENABLE:   rdata_next = set_enable_reg;
                OFS_SET_IRQ_EN:   rdata_next = irq_enable_reg;
                OFS_INDEX_SELECT: rdata_next = index_select_reg;
                OFS_XFER_FLAGS:   rdata_next = {4'h0, flags_reg};
                OFS_WINDOW_PORT:  rdata_next = window_rd;
                default:          rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= rdata_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs to the transfer engine, straight from the flops
    assign pointer_set_enable = set_enable_reg[3:0];
    assign set_index_select   = sel_set;

    for (genvar s = 0; s < 4; s++)
    begin : g_ptr_out
        assign base_pointer[s*PTR_W +: PTR_W] =
            ptr_reg[ptr_slot(2'(s), PTR_BASE)];
        assign read_pointer[s*PTR_W +: PTR_W] =
            ptr_reg[ptr_slot(2'(s), PTR_READ)];
        assign write_pointer[s*PTR_W +: PTR_W] =
            ptr_reg[ptr_slot(2'(s), PTR_WRITE)];
        assign temporary_pointer[s*PTR_W +: PTR_W] =
            ptr_reg[ptr_slot(2'(s), PTR_TEMP)];
    end

endmodule // fsucr_regs
`default_nettype wire

// ==== tb/fsucr_regs_asserts.sv ====
`default_nettype none
module fsucr_regs_chk
    import fsucr_pkg::*;
(
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [3:0] buffer_overflow_read,
    input wire logic [3:0] buffer_overflow_write,
    input wire logic [3:0] fifo_full,
    input wire logic [3:0] fifo_empty,
    input wire logic [3:0] pointer_set_enable,
    input wire logic [3:0] empty_restore,
    input wire logic [2:0] set_index_select,
    input wire logic       transfer_irq
);
    logic [3:0] cond_v;
    assign cond_v = buffer_overflow_read | buffer_overflow_write |
                    fifo_full | fifo_empty;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////
    sequence s_en_wr;
        reg_wr && reg_addr == OFS_SET_ENABLE;
    endsequence
    property p_rst_zero;
        $past(sys_rst) |-> pointer_set_enable == 4'h0 && empty_restore == 4'h0
            && set_index_select == 3'h0 && transfer_irq == 1'b0;
    endproperty
    property p_en_wr;
        s_en_wr |=> pointer_set_enable == $past(reg_wdata[3:0]);
    endproperty
    property p_restore;
        s_en_wr |=> empty_restore ==
            ($past(reg_wdata[3:0]) & ~$past(pointer_set_enable));
    endproperty
    property p_en_hold;
        !(reg_wr && reg_addr == OFS_SET_ENABLE)
            |=> $stable(pointer_set_enable) && empty_restore == 4'h0;
    endproperty
    property p_idx;
        reg_wr && reg_addr == OFS_INDEX_SELECT
            |=> set_index_select == $past(reg_wdata[7:5]);
    endproperty
    property p_idfunc;
        reg_rd && reg_addr == OFS_ID_FUNC_CTRL |=> reg_rdata[5:0] == 6'h00;
    endproperty
    property p_rd_idle;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    // rise needs a write or one set's condition edge two cycles back
    property p_irq_rise;
        $rose(transfer_irq) |-> $past(reg_wr, 2)
            || (|($past(cond_v, 2) & ~$past(cond_v, 3)));
    endproperty
    property p_irq_fall;
        $fell(transfer_irq) |-> $past(reg_wr, 2);
    endproperty
    a_rst_zero: assert property (p_rst_zero)
        else $error("output not zero after reset");
    a_en_wr: assert property (p_en_wr)
        else $error("enable bits not written");
    a_restore: assert property (p_restore)
        else $error("empty restore pulse wrong");
    a_en_hold: assert property (p_en_hold)
        else $error("enable bits moved without write");
    a_idx: assert property (p_idx)
        else $error("set index not written");
    a_idfunc: assert property (p_idfunc)
        else $error("id function low bits not zero");
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read slot");
    a_irq_rise: assert property (p_irq_rise)
        else $error("interrupt rose without cause");
    a_irq_fall: assert property (p_irq_fall)
        else $error("interrupt fell without write");
endmodule // fsucr_regs_chk
`default_nettype wire

// ==== tb/tb_fsucr_regs.sv ====
`default_nettype none
module tb_fsucr_regs
    import fsucr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    logic [15:0] cond = 16'h0000; // empty, full, ovf write, ovf read
    logic [31:0] sv [4] = '{32'h13121110, 32'h23222120,
                            32'h33323130, 32'h43424140};
    logic [31:0] pv [4];
    logic [3:0]  pointer_set_enable;
    logic [3:0]  empty_restore;
    logic [2:0]  set_index_select;
    logic        transfer_irq;
    int          bad_count = 0;
    int          total_checks = 0;
    fsucr_regs uut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .buffer_overflow_read(cond[3:0]),
        .buffer_overflow_write(cond[7:4]), .fifo_full(cond[11:8]),
        .fifo_empty(cond[15:12]), .valid_byte_count(sv[0]),
        .free_byte_count(sv[1]), .next_read_start(sv[2]),
        .next_write_start(sv[3]), .pointer_set_enable(pointer_set_enable),
        .empty_restore(empty_restore), .set_index_select(set_index_select),
        .base_pointer(pv[0]), .read_pointer(pv[1]), .write_pointer(pv[2]),
        .temporary_pointer(pv[3]), .transfer_irq(transfer_irq));
    always #25 clk = ~clk;
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic do_rst;
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic t_reset;
        logic [7:0] d;
        for (int a = 0; a < 5; a++)
        begin
            rd(a[3:0], d);
            chk(d, 8'h00);
        end
        wr(4'hf, 8'hff);
        rd(4'hf, d);
        chk(d, 8'h00);
    endtask
    task automatic t_enable;
        logic [7:0] d;
        logic [7:0] v [4] = '{8'h05, 8'h0c, 8'h00, 8'h0f};
        logic [3:0] e [4] = '{4'h5, 4'h8, 4'h0, 4'hf};
        for (int i = 0; i < 4; i++)
        begin
            wr(OFS_SET_ENABLE, v[i]);
            chk(empty_restore, e[i]);
            chk(pointer_set_enable, v[i][3:0]);
        end
        rd(OFS_SET_ENABLE, d);
        chk(d, 8'h0f);
    endtask
    task automatic t_idfunc;
        logic [7:0] d;
        wr(OFS_ID_FUNC_CTRL, 8'hff);
        rd(OFS_ID_FUNC_CTRL, d);
        chk(d, 8'hc0);
        wr(OFS_ID_FUNC_CTRL, 8'h00);
    endtask
    task automatic t_window;
        logic [7:0] d;
        for (int p = 0; p < 4; p++)
        begin
            wr(OFS_INDEX_SELECT, {3'h2, 1'b0, p[1:0], 2'h0});
            chk(set_index_select, 3'h2);
            wr(OFS_WINDOW_PORT, 8'ha0 + p[7:0]);
            chk(pv[p][23:16], 8'ha0 + p);
            chk(pv[p][7:0], 8'h00);
            rd(OFS_WINDOW_PORT, d);
            chk(d, 8'ha0 + p);
        end
        // single kind write only arms, window still on base pointer
        wr(OFS_INDEX_SELECT, 8'h50);
        rd(OFS_WINDOW_PORT, d);
        chk(d, 8'ha0);
        for (int s = 0; s < 4; s++)
        begin
            wr(OFS_INDEX_SELECT, {3'h2, 1'b1, 2'h0, s[1:0]});
            rd(OFS_WINDOW_PORT, d);
            chk(d, 8'h12 + 8'h10 * s);
        end
        // status side is read only, out-of-range sets reach nothing
        wr(OFS_WINDOW_PORT, 8'h77);
        chk(pv[0], 32'h00a00000);
        wr(OFS_INDEX_SELECT, 8'hc0);
        wr(OFS_WINDOW_PORT, 8'h77);
        rd(OFS_WINDOW_PORT, d);
        chk(d, 8'h00);
        chk(pv[0], 32'h00a00000);
    endtask
    task automatic t_irq;
        logic [7:0] d;
        wr(OFS_SET_IRQ_EN, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            cond[5 * i] <= 1'b1;
        end
        repeat (3) @(posedge clk);
        #1 chk(transfer_irq, 1'b0);
        rd(OFS_XFER_FLAGS, d);
        chk(d[3:0], 4'hf);
        wr(OFS_XFER_FLAGS, 8'h0b);
        rd(OFS_XFER_FLAGS, d);
        chk(d[3:0], 4'hb);
        wr(OFS_SET_IRQ_EN, 8'h04);
        repeat (2) @(posedge clk);
        #1 chk(transfer_irq, 1'b0);
        wr(OFS_SET_IRQ_EN, 8'h02);
        repeat (2) @(posedge clk);
        #1 chk(transfer_irq, 1'b1);
        wr(OFS_XFER_FLAGS, 8'h00);
        repeat (2) @(posedge clk);
        #1 chk(transfer_irq, 1'b0);
    endtask
    initial
    begin
        logic [7:0] d;
        do_rst;
        t_reset;
        t_enable;
        t_idfunc;
        t_window;
        t_irq;
        // conditions stay high across reset, release must not flag them
        do_rst;
        chk(pointer_set_enable, 4'h0);
        rd(OFS_XFER_FLAGS, d);
        chk(d, 8'h00);
        print_verdict;
    end
endmodule // tb_fsucr_regs
bind fsucr_regs fsucr_regs_chk u_chk (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .buffer_overflow_read(buffer_overflow_read),
    .buffer_overflow_write(buffer_overflow_write), .fifo_full(fifo_full),
    .fifo_empty(fifo_empty), .pointer_set_enable(pointer_set_enable),
    .empty_restore(empty_restore), .set_index_select(set_index_select),
    .transfer_irq(transfer_irq));
`default_nettype wire
